// ---- src/rps_cfg.svh ----
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH
// Register byte addresses
`define RPS_ADDR_PORTSC      8'h00
`define RPS_ADDR_IRQ_STATUS  8'h04
`define RPS_ADDR_IRQ_MASK    8'h08
`define RPS_ADDR_STAT_REQ    8'h0C
// Port status field positions
`define RPS_BIT_CONNECT      0
`define RPS_BIT_CONN_CHG     1
`define RPS_BIT_ENABLE       2
`define RPS_BIT_EN_CHG       3
`define RPS_BIT_LINE_DP      4
`define RPS_BIT_LINE_DM      5
`define RPS_BIT_RSVD_ONE     7
`define RPS_BIT_SUSPEND      12
// Interrupt status bits
`define RPS_IRQ_CONN_CHG     0
`define RPS_IRQ_EN_CHG       1
// Reset values
`define RPS_PORTSC_RESET     16'h0080
`define RPS_IRQ_RESET        2'h0
`endif

// ---- src/rps_pkg.sv ----
package rps_pkg;
    // Port state decoded from enable and suspend
    typedef enum logic [1:0]
    {
        RPS_DISABLED  = 2'h0,
        RPS_ENABLED   = 2'h1,
        RPS_SUSPENDED = 2'h3
    } rps_port_state_t;

    // Link-side inputs after synchronisation
    typedef struct packed
    {
        logic connect;
        logic line_dp;
        logic line_dm;
    } rps_link_t;

    // Whole module state
    typedef struct packed
    {
        logic [2:0] conn_sync;
        logic [2:0] dp_sync;
        logic [2:0] dm_sync;
        logic       connect;
        logic       line_dp;
        logic       line_dm;
        logic       enable;
        logic       en_req;
        logic       en_pend;
        logic       en_chg;
        logic       conn_chg;
        logic       reported;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic       ph_valid;
        logic       ph_write;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic       rpt_pulse;
    } rps_state_t;
endpackage

// ---- src/rps_top.sv ----
`include "rps_cfg.svh"
// How it works
// - Bits 4 and 5 show the D+ and D- levels, captured at each end-of-frame (EOF2) strobe where the last two synchroniser stages agree.
// - Bit 3 sets only when the port drops to disabled through disconnect or an end-of-frame fault; writing one clears it.
// - Bit 2 is set only by a software write of one; hardware clears it on disconnect or fault, software may clear it.
// - Bit 2 readback follows the real port state, so a software change waits until no transaction is in progress.
// - Bit 1 sets on every connect change, staying set if already set; writing one clears it.
// - Bit 0 shows whether a device is attached right now.
// - A pending connect change is handed to the status-change endpoint once, on the first request after it.
// - Enable clear means disabled, enable with suspend clear means enabled, both set means suspended.
module rps_top
    import rps_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,
    // AHB-Lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic [31:0]      HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    // Port pins and link timing
    input  wire logic        CONNECT_IN,
    input  wire logic        LINE_DP_IN,
    input  wire logic        LINE_DM_IN,
    input  wire logic        EOF2_IN,
    input  wire logic        FAULT_IN,
    input  wire logic        BUSY_IN,
    // Neighbouring suspend bit
    input  wire logic        SUSPEND_IN,
    // Status-change endpoint
    input  wire logic        STAT_REQ_IN,
    output logic             STAT_CHG_OUT,
    output logic             STAT_VALID_OUT,
    // Port state and interrupt
    output logic             PORT_ENABLE_OUT,
    output rps_port_state_t  PORT_STATE_OUT,
    output logic             IRQ_OUT
);

    rps_state_t s_q;
    rps_state_t s_d;

    logic        wr_en;
    logic [15:0] wr_lo;
    logic [15:0] portsc_rd;
    logic        conn_now;
    logic        conn_edge;
    logic        disc;
    logic        eof_fault;
    logic [1:0]  irq_set;

    // Synchronised pin values: stable once stages two and three agree
    assign conn_now  = (s_q.conn_sync[2] == s_q.conn_sync[1]) ? s_q.conn_sync[1] : s_q.connect;
    assign conn_edge = conn_now != s_q.connect;
    assign disc      = conn_edge && !conn_now;
    assign eof_fault = EOF2_IN && FAULT_IN;

    // Write data phase decode
    assign wr_en = s_q.ph_valid && s_q.ph_write;
    assign wr_lo = HWDATA_IN[15:0];

    // Register readback; bit 7 is reserved and reads one
    always_comb
    begin
        portsc_rd = 16'h0000;
        portsc_rd[`RPS_BIT_CONNECT]  = s_q.connect;
        portsc_rd[`RPS_BIT_CONN_CHG] = s_q.conn_chg;
        portsc_rd[`RPS_BIT_ENABLE]   = s_q.enable;
        portsc_rd[`RPS_BIT_EN_CHG]   = s_q.en_chg;
        portsc_rd[`RPS_BIT_LINE_DP]  = s_q.line_dp;
        portsc_rd[`RPS_BIT_LINE_DM]  = s_q.line_dm;
        portsc_rd[`RPS_BIT_RSVD_ONE] = 1'b1;
        portsc_rd[`RPS_BIT_SUSPEND]  = SUSPEND_IN;
    end

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        irq_set    = 2'h0;
        s_d.rpt_pulse = 1'b0;

        // Three-stage synchronisers
        s_d.conn_sync = {s_q.conn_sync[1:0], CONNECT_IN};
        s_d.dp_sync   = {s_q.dp_sync[1:0], LINE_DP_IN};
        s_d.dm_sync   = {s_q.dm_sync[1:0], LINE_DM_IN};
        s_d.connect   = conn_now;

        // Line levels latched only at the end-of-frame strobe
        if (EOF2_IN)
        begin
            if (s_q.dp_sync[2] == s_q.dp_sync[1])
                s_d.line_dp = s_q.dp_sync[1];
            if (s_q.dm_sync[2] == s_q.dm_sync[1])
                s_d.line_dm = s_q.dm_sync[1];
        end

        // Software clears change flags first so a same-cycle set wins
        if (wr_en && s_q.ph_addr == `RPS_ADDR_PORTSC)
        begin
            if (wr_lo[`RPS_BIT_CONN_CHG])
                s_d.conn_chg = 1'b0;
            if (wr_lo[`RPS_BIT_EN_CHG])
                s_d.en_chg = 1'b0;
            // A write request is held until the bus is idle
            s_d.en_req  = wr_lo[`RPS_BIT_ENABLE];
            s_d.en_pend = 1'b1;
        end

        // Connect change sets the flag, even if already set
        if (conn_edge)
        begin
            s_d.conn_chg = 1'b1;
            s_d.reported = 1'b0;
            irq_set[`RPS_IRQ_CONN_CHG] = 1'b1;
        end

        // Hardware disable on disconnect or end-of-frame fault
        if (s_q.enable && (disc || eof_fault))
        begin
            s_d.enable = 1'b0;
            s_d.en_chg = 1'b1;
            s_d.en_pend = 1'b0;
            irq_set[`RPS_IRQ_EN_CHG] = 1'b1;
        end
        else if (s_q.en_pend && !BUSY_IN)
        begin
            // Readback moves only when the port really switches
            s_d.enable  = s_q.en_req && conn_now;
            s_d.en_pend = 1'b0;
        end

        // Status-change endpoint: one report per connect change
        if (STAT_REQ_IN && s_q.conn_chg && !s_q.reported && !conn_edge)
        begin
            s_d.rpt_pulse = 1'b1;
            s_d.reported  = 1'b1;
        end

        // Interrupt status: clear by writing one, set wins
        if (wr_en && s_q.ph_addr == `RPS_ADDR_IRQ_STATUS)
            s_d.irq_stat = s_q.irq_stat & ~HWDATA_IN[1:0];
        s_d.irq_stat = s_d.irq_stat | irq_set;
        if (wr_en && s_q.ph_addr == `RPS_ADDR_IRQ_MASK)
            s_d.irq_mask = HWDATA_IN[1:0];

        // Address phase capture
        s_d.ph_valid = HSEL_IN && HREADY_IN && HTRANS_IN[1];
        if (HREADY_IN)
        begin
            s_d.ph_write = HWRITE_IN;
            s_d.ph_addr  = HADDR_IN[7:0];
        end
        if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN)
        begin
            // Unmapped addresses read zero
            case (HADDR_IN[7:0])
                `RPS_ADDR_PORTSC:     s_d.rdata = {16'h0000, portsc_rd};
                `RPS_ADDR_IRQ_STATUS: s_d.rdata = {30'h00000000, s_q.irq_stat};
                `RPS_ADDR_IRQ_MASK:   s_d.rdata = {30'h00000000, s_q.irq_mask};
                `RPS_ADDR_STAT_REQ:   s_d.rdata = {31'h00000000, s_q.reported};
                default:              s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs; the slave never stalls, so hsize is not checked
    assign HRDATA_OUT      = s_q.rdata;
    assign HREADYOUT_OUT   = 1'b1;
    assign HRESP_OUT       = 1'b0;
    assign STAT_CHG_OUT    = s_q.conn_chg && !s_q.reported;
    assign STAT_VALID_OUT  = s_q.rpt_pulse;
    assign PORT_ENABLE_OUT = s_q.enable;
    assign IRQ_OUT         = |(s_q.irq_stat & s_q.irq_mask);

    // Port state decode
    always_comb
    begin
        if (!s_q.enable)
            PORT_STATE_OUT = RPS_DISABLED;
        else if (SUSPEND_IN)
            PORT_STATE_OUT = RPS_SUSPENDED;
        else
            PORT_STATE_OUT = RPS_ENABLED;
    end

endmodule

// ---- sim/rps_top_monitor.sv ----
module rps_top_monitor
    import rps_pkg::*;
(
    // Clock, reset and bus
    input wire logic            CLOCK_IN,
    input wire logic            RST_IN,
    input wire logic            HREADYOUT_OUT,
    input wire logic            HRESP_OUT,
    // Port side
    input wire logic            CONNECT_IN,
    input wire logic            EOF2_IN,
    input wire logic            FAULT_IN,
    input wire logic            BUSY_IN,
    input wire logic            SUSPEND_IN,
    input wire logic            STAT_REQ_IN,
    input wire logic            STAT_CHG_OUT,
    input wire logic            STAT_VALID_OUT,
    input wire logic            PORT_ENABLE_OUT,
    input wire rps_port_state_t PORT_STATE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    // One report pulse, then low again on the next cycle
    sequence s_report; STAT_VALID_OUT ##1 !STAT_VALID_OUT; endsequence
    property p_bus; HREADYOUT_OUT; endproperty
    a_bus: assert property (p_bus) else $error("wait state inserted");
    // Every access is answered OKAY
    property p_okay; !HRESP_OUT; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_state; PORT_STATE_OUT == (PORT_ENABLE_OUT ? (SUSPEND_IN ? RPS_SUSPENDED : RPS_ENABLED) : RPS_DISABLED); endproperty
    a_state: assert property (p_state) else $error("port state decode wrong");
    // A software enable must have waited for the bus to go quiet
    property p_rise; $rose(PORT_ENABLE_OUT) |-> !$past(BUSY_IN); endproperty
    a_rise: assert property (p_rise) else $error("enable during transaction");
    property p_fault; PORT_ENABLE_OUT && EOF2_IN && FAULT_IN |=> !PORT_ENABLE_OUT; endproperty
    a_fault: assert property (p_fault) else $error("fault did not disable");
    // Detach passes the synchroniser before it disables
    property p_disc; $fell(CONNECT_IN) && PORT_ENABLE_OUT |-> ##[1:6] !PORT_ENABLE_OUT; endproperty
    a_disc: assert property (p_disc) else $error("detach did not disable");
    property p_conn; $changed(CONNECT_IN) |-> ##[1:6] STAT_CHG_OUT; endproperty
    a_conn: assert property (p_conn) else $error("connect change not flagged");
    property p_pulse; STAT_VALID_OUT |-> s_report; endproperty
    a_pulse: assert property (p_pulse) else $error("report longer than a cycle");
    property p_cause; STAT_VALID_OUT |-> $past(STAT_REQ_IN && STAT_CHG_OUT) && !STAT_CHG_OUT; endproperty
    a_cause: assert property (p_cause) else $error("report without request");
endmodule
bind rps_top rps_top_monitor u_mon (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
    .HRESP_OUT(HRESP_OUT),
    .CONNECT_IN(CONNECT_IN), .EOF2_IN(EOF2_IN), .FAULT_IN(FAULT_IN), .BUSY_IN(BUSY_IN), .SUSPEND_IN(SUSPEND_IN),
    .STAT_REQ_IN(STAT_REQ_IN), .STAT_CHG_OUT(STAT_CHG_OUT), .STAT_VALID_OUT(STAT_VALID_OUT),
    .PORT_ENABLE_OUT(PORT_ENABLE_OUT), .PORT_STATE_OUT(PORT_STATE_OUT));

// ---- sim/rps_usb_dev.sv ----
module rps_usb_dev
(
    // Test control
    input  wire logic attach_in,
    input  wire logic ls_in,
    // Pins seen by the port
    output logic      connect_out,
    output logic      dp_out,
    output logic      dm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle level only; detached, the host pull-downs take both lines low
    assign connect_out = attach_in;
    assign dp_out      = attach_in & ~ls_in;
    assign dm_out      = attach_in & ls_in;
endmodule

// ---- sim/tb_rps_top.sv ----
`include "rps_cfg.svh"
module tb_rps_top
    import rps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk, rst, hw, att, ls, eof2, flt, busy, susp, sreq, rdy, dp, dm, con, chg, vld, pen, irq;
    logic [1:0]      ht;
    logic [31:0]     ha, wd, rd;
    rps_port_state_t pst;
    int              failures, check_count, cyc, pulses;
    rps_usb_dev dev (.attach_in(att), .ls_in(ls), .connect_out(con), .dp_out(dp), .dm_out(dm));
    rps_top dut (.CLOCK_IN(clk), .RST_IN(rst), .HSEL_IN(1'h1), .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw),
        .HSIZE_IN(3'h2), .HWDATA_IN(wd), .HREADY_IN(rdy), .HRDATA_OUT(rd), .HREADYOUT_OUT(rdy), .HRESP_OUT(),
        .CONNECT_IN(con), .LINE_DP_IN(dp), .LINE_DM_IN(dm), .EOF2_IN(eof2), .FAULT_IN(flt), .BUSY_IN(busy),
        .SUSPEND_IN(susp), .STAT_REQ_IN(sreq), .STAT_CHG_OUT(chg), .STAT_VALID_OUT(vld),
        .PORT_ENABLE_OUT(pen), .PORT_STATE_OUT(pst), .IRQ_OUT(irq));
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    // Watchdog and report counter; the sequence needs well under 600 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        pulses <= pulses + (vld === 1'h1);
        if (cyc == 3000)
        begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One single AHB-Lite transfer; read data taken at the edge closing the data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        ht <= 2'h2;
        ha <= {24'h0, a};
        hw <= w;
        do @(posedge clk); while (rdy !== 1'h1);
        ht <= 2'h0;
        wd <= d;
        do @(posedge clk); while (rdy !== 1'h1);
        if (!w) chk(rd, e);
    endtask
    task automatic ps(input logic [31:0] e);
        xfer(1'h0, `RPS_ADDR_PORTSC, 32'h0, e);
    endtask
    task automatic wp(input logic [31:0] d);
        xfer(1'h1, `RPS_ADDR_PORTSC, d, 32'h0);
    endtask
    // Strobe the end-of-frame point, optionally with a fault standing
    task automatic eof(input logic f);
        @(posedge clk);
        eof2 <= 1'h1;
        flt <= f;
        @(posedge clk);
        eof2 <= 1'h0;
        flt <= 1'h0;
    endtask
    initial
    begin
        {rst, hw, att, ls, eof2, flt, busy, susp, sreq, ht, ha, wd} = {9'h100, 66'h0};
        {cyc, pulses, failures, check_count} = 128'h0;
        tick(2);
        rst <= 1'h0;
        ps(32'h80);
        xfer(1'h0, `RPS_ADDR_IRQ_MASK, 32'h0, 32'h0);
        xfer(1'h0, 8'h10, 32'h0, 32'h0);
        // No device yet, so an enable write is dropped
        wp(32'h4);
        tick(3);
        chk(pen, 32'h0);
        att <= 1'h1;
        tick(8);
        chk(irq, 32'h0);
        ps(32'h83);
        eof(1'h0);
        ps(32'h93);
        wp(32'h31);
        ps(32'h93);
        // A request held for several cycles still gets one report
        sreq <= 1'h1;
        tick(6);
        sreq <= 1'h0;
        chk(pulses, 32'h1);
        wp(32'h2);
        ps(32'h91);
        busy <= 1'h1;
        wp(32'h4);
        tick(4);
        chk(pen, 32'h0);
        busy <= 1'h0;
        tick(3);
        chk(pen, 32'h1);
        ps(32'h95);
        susp <= 1'h1;
        tick(1);
        chk(pst, RPS_SUSPENDED);
        susp <= 1'h0;
        // Fault at the frame end disables, flags, and raises the unmasked interrupt
        xfer(1'h1, `RPS_ADDR_IRQ_MASK, 32'h3, 32'h0);
        eof(1'h1);
        tick(1);
        chk(pen, 32'h0);
        chk(irq, 32'h1);
        ps(32'h99);
        xfer(1'h0, `RPS_ADDR_IRQ_STATUS, 32'h0, 32'h3);
        xfer(1'h1, `RPS_ADDR_IRQ_STATUS, 32'h3, 32'h0);
        tick(2);
        chk(irq, 32'h0);
        wp(32'h8);
        ls <= 1'h1;
        tick(5);
        eof(1'h0);
        wp(32'h4);
        tick(2);
        att <= 1'h0;
        tick(8);
        ps(32'hAA);
        close_out();
    end
endmodule
